// ---- mrb_pkg.sv ----
package mrb_pkg;
  // ==========================================================
  // Sizes
  localparam int NCPU   = 4;
  localparam int CPU_W  = 2;
  localparam int QPER   = 2;
  localparam int QDEPTH = 8;
  localparam int QPTR_W = 3;
  localparam int PA_W   = 48;
  // ==========================================================
  // Pointer register layout and its single system-wide address
  localparam int          MBX_LSB    = 6;
  localparam int          MBX_MSB    = 47;
  localparam logic [47:0] MBPTR_ADDR = 48'h0000_0F00_0000;
  // ==========================================================
  // Mailbox byte offsets
  localparam logic [5:0] OFF_CMD   = 6'h00;
  localparam logic [5:0] OFF_ADDR  = 6'h08;
  localparam logic [5:0] OFF_WDATA = 6'h10;
  localparam logic [5:0] OFF_RDATA = 6'h20;
  localparam logic [5:0] OFF_DONE  = 6'h28;
  // ==========================================================
  // First quadword fields and completion quadword fields
  localparam int CMD_MSB     = 29;
  localparam int SPECIAL_BIT = 30;
  localparam int WRITE_BIT   = 31;
  localparam int MASK_LSB    = 32;
  localparam int MASK_MSB    = 39;
  localparam int HOSE_LSB    = 48;
  localparam int HOSE_MSB    = 55;
  localparam int DONE_BIT    = 0;
  localparam int ERR_BIT     = 1;
  localparam int STATUS_LSB  = 2;
  // ==========================================================
  // Host register map (byte addresses)
  localparam logic [7:0] REG_PTR_LO  = 8'h00;
  localparam logic [7:0] REG_PTR_HI  = 8'h04;
  localparam logic [7:0] REG_CTRL    = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0C;
  localparam logic [7:0] REG_RETRIES = 8'h10;
  localparam logic [7:0] REG_CPU_ID  = 8'h14;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int BACKOFF_NS    = 200;
  localparam int BACKOFF_CYC   = BACKOFF_NS / CLK_PERIOD_NS;
endpackage

// ---- mrb_if.sv ----
`timescale 1ns/100ps
interface mrb_if;
  // Conditional quadword store from a processor to the pointer register.
  logic                       post_valid;
  logic [47:0]                post_addr;
  logic [mrb_pkg::CPU_W-1:0]  post_cpu;
  logic [63:0]                post_data;
  // Answer: one-cycle pulse, success flag and the processor it belongs to.
  logic                       post_ack;
  logic                       post_ok;
  logic [mrb_pkg::CPU_W-1:0]  post_ack_cpu;

  modport bridge (
    input  post_valid,
    input  post_addr,
    input  post_cpu,
    input  post_data,
    output post_ack,
    output post_ok,
    output post_ack_cpu
  );
  modport cpu (
    output post_valid,
    output post_addr,
    output post_cpu,
    output post_data,
    input  post_ack,
    input  post_ok,
    input  post_ack_cpu
  );
endinterface

// ---- mrb_bridge.sv ----
`timescale 1ns/100ps
module mrb_bridge (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Processor posting port
  mrb_if.bridge            post,
  // System memory port; mem_ack completes the held request
  output logic             mem_req,
  output logic             mem_we,
  output logic [47:0]      mem_addr,
  output logic [63:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [63:0] mem_rdata,
  // Remote bus port; rb_ack completes the held request
  output logic             rb_req,
  output logic             rb_write,
  output logic             rb_special,
  output logic [29:0]      rb_cmd,
  output logic [7:0]       rb_mask,
  output logic [7:0]       rb_hose,
  output logic [63:0]      rb_addr,
  output logic [63:0]      rb_wdata,
  input  wire logic        rb_ack,
  input  wire logic        rb_err,
  input  wire logic [61:0] rb_status,
  input  wire logic [31:0] rb_rdata
);
  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_FETCH_CMD  = 3'b001,
    ST_FETCH_ADDR = 3'b010,
    ST_FETCH_DATA = 3'b011,
    ST_REMOTE     = 3'b100,
    ST_PUT_RDATA  = 3'b101,
    ST_PUT_DONE   = 3'b110
  } mrb_state_t;

  localparam int MBX_W = mrb_pkg::MBX_MSB - mrb_pkg::MBX_LSB + 1;

  // ==========================================================
  // Posting queue
  // A single queue in posting order keeps same-hose ordering for free; the
  // price is that a slow hose holds back the others.
  logic [MBX_W-1:0]               q_ptr_reg [mrb_pkg::QDEPTH];
  logic [mrb_pkg::CPU_W-1:0]      q_cpu_reg [mrb_pkg::QDEPTH];
  logic [mrb_pkg::QPTR_W-1:0]     q_wr_reg;
  logic [mrb_pkg::QPTR_W-1:0]     q_rd_reg;
  logic [mrb_pkg::QPTR_W:0]       q_count_reg;
  logic [1:0]                     cpu_cnt_reg [mrb_pkg::NCPU];
  logic                           ack_reg;
  logic                           ok_reg;
  logic [mrb_pkg::CPU_W-1:0]      ack_cpu_reg;
  mrb_state_t                     state_reg;
  logic                           take;
  logic                           accept;
  logic                           pop;

  assign take   = post.post_valid && !ack_reg;
  assign accept = take && (post.post_addr == mrb_pkg::MBPTR_ADDR)
               && (q_count_reg != 4'(mrb_pkg::QDEPTH))
               && (cpu_cnt_reg[post.post_cpu] != 2'(mrb_pkg::QPER));
  assign pop    = (state_reg == ST_IDLE) && (q_count_reg != '0);

  // The answer is seen by every processor, tagged with the issuing one in post_ack_cpu.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg     <= 1'b0;
      ok_reg      <= 1'b0;
      ack_cpu_reg <= '0;
    end else begin
      ack_reg     <= take;
      ok_reg      <= accept;
      ack_cpu_reg <= post.post_cpu;
    end
  end
  assign post.post_ack     = ack_reg;
  assign post.post_ok      = ok_reg;
  assign post.post_ack_cpu = ack_cpu_reg;

  always_ff @(posedge ref_clk) begin
    if (accept) begin
      q_ptr_reg[q_wr_reg] <= post.post_data[mrb_pkg::MBX_MSB:mrb_pkg::MBX_LSB];
      q_cpu_reg[q_wr_reg] <= post.post_cpu;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_wr_reg    <= '0;
      q_rd_reg    <= '0;
      q_count_reg <= '0;
    end else begin
      if (accept) begin
        q_wr_reg <= q_wr_reg + 3'd1;
      end
      if (pop) begin
        q_rd_reg <= q_rd_reg + 3'd1;
      end
      q_count_reg <= q_count_reg + {3'd0, accept} - {3'd0, pop};
    end
  end

  // Per-processor occupancy: no processor may hold more than its quota.
  localparam int CPU_W = mrb_pkg::CPU_W;

  for (genvar g = 0; g < mrb_pkg::NCPU; g++) begin : g_quota
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        cpu_cnt_reg[g] <= '0;
      end else begin
        cpu_cnt_reg[g] <= cpu_cnt_reg[g]
          + {1'b0, accept && (post.post_cpu == CPU_W'(g))}
          - {1'b0, pop && (q_cpu_reg[q_rd_reg] == CPU_W'(g))};
      end
    end
  end

  // ==========================================================
  // Mailbox sequencer
  // Only memory and the remote bus ever stall it, so other traffic on the
  // interconnect cannot hold a mailbox back beyond its own accesses.
  logic [MBX_W-1:0] base_reg;
  logic [63:0]      cmd_reg;
  logic [63:0]      done_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      base_reg  <= '0;
      cmd_reg   <= '0;
      done_reg  <= '0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
      rb_req    <= 1'b0;
      rb_addr   <= '0;
      rb_wdata  <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (pop) begin
            base_reg  <= q_ptr_reg[q_rd_reg];
            mem_req   <= 1'b1;
            mem_we    <= 1'b0;
            mem_addr  <= {q_ptr_reg[q_rd_reg], mrb_pkg::OFF_CMD};
            state_reg <= ST_FETCH_CMD;
          end
        end
        ST_FETCH_CMD: begin
          if (mem_ack) begin
            cmd_reg   <= mem_rdata;
            mem_addr  <= {base_reg, mrb_pkg::OFF_ADDR};
            state_reg <= ST_FETCH_ADDR;
          end
        end
        ST_FETCH_ADDR: begin
          if (mem_ack) begin
            rb_addr <= mem_rdata;
            if (cmd_reg[mrb_pkg::WRITE_BIT]) begin
              mem_addr  <= {base_reg, mrb_pkg::OFF_WDATA};
              state_reg <= ST_FETCH_DATA;
            end else begin
              // Reads skip the write data and never fetch completion fields.
              mem_req   <= 1'b0;
              rb_req    <= 1'b1;
              state_reg <= ST_REMOTE;
            end
          end
        end
        ST_FETCH_DATA: begin
          if (mem_ack) begin
            rb_wdata  <= mem_rdata;
            mem_req   <= 1'b0;
            rb_req    <= 1'b1;
            state_reg <= ST_REMOTE;
          end
        end
        ST_REMOTE: begin
          if (rb_ack) begin
            rb_req   <= 1'b0;
            done_reg <= {rb_status, rb_err, 1'b1};
            mem_req  <= 1'b1;
            mem_we   <= 1'b1;
            if (cmd_reg[mrb_pkg::WRITE_BIT]) begin
              // The write is reported done once the remote side accepted it.
              mem_addr  <= {base_reg, mrb_pkg::OFF_DONE};
              mem_wdata <= {rb_status, rb_err, 1'b1};
              state_reg <= ST_PUT_DONE;
            end else begin
              mem_addr  <= {base_reg, mrb_pkg::OFF_RDATA};
              mem_wdata <= {32'h0000_0000, rb_rdata};
              state_reg <= ST_PUT_RDATA;
            end
          end
        end
        ST_PUT_RDATA: begin
          if (mem_ack) begin
            mem_addr  <= {base_reg, mrb_pkg::OFF_DONE};
            mem_wdata <= done_reg;
            state_reg <= ST_PUT_DONE;
          end
        end
        ST_PUT_DONE: begin
          if (mem_ack) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          mem_req   <= 1'b0;
          rb_req    <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Remote request fields, straight from the fetched first quadword
  assign rb_cmd     = cmd_reg[mrb_pkg::CMD_MSB:0];
  assign rb_special = cmd_reg[mrb_pkg::SPECIAL_BIT];
  assign rb_write   = cmd_reg[mrb_pkg::WRITE_BIT];
  assign rb_mask    = cmd_reg[mrb_pkg::MASK_MSB:mrb_pkg::MASK_LSB];
  assign rb_hose    = cmd_reg[mrb_pkg::HOSE_MSB:mrb_pkg::HOSE_LSB];
endmodule

// ---- mrb_cpu.sv ----
`timescale 1ns/100ps
module mrb_cpu (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Posting port toward the bridge
  mrb_if.cpu               post,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);
  // ==========================================================
  // Register slave
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [47:0] ptr_reg;
  logic [1:0]  cpu_id_reg;
  logic [15:0] retries_reg;
  logic        busy_reg;
  logic        wr_fire;
  logic        go;
  logic        rd_hit;
  logic [31:0] rd_val;

  assign s_axi_awready = !aw_got_reg;
  assign s_axi_wready  = !w_got_reg;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign go      = wr_fire && (awaddr_reg == mrb_pkg::REG_CTRL) && wdata_reg[0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mrb_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg <= mrb_pkg::REG_CPU_ID) ? mrb_pkg::RESP_OKAY
                                                            : mrb_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Pointer and processor number; changes are ignored while a post is pending.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg    <= '0;
      cpu_id_reg <= '0;
    end else if (wr_fire && !busy_reg) begin
      case (awaddr_reg)
        mrb_pkg::REG_PTR_LO: ptr_reg[31:0]  <= wdata_reg;
        mrb_pkg::REG_PTR_HI: ptr_reg[47:32] <= wdata_reg[15:0];
        mrb_pkg::REG_CPU_ID: cpu_id_reg     <= wdata_reg[1:0];
        default:             ptr_reg        <= ptr_reg;
      endcase
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      mrb_pkg::REG_PTR_LO:  rd_val = ptr_reg[31:0];
      mrb_pkg::REG_PTR_HI:  rd_val = {16'h0000, ptr_reg[47:32]};
      mrb_pkg::REG_CTRL:    rd_val = 32'h0000_0000;
      mrb_pkg::REG_STATUS:  rd_val = {31'h0000_0000, busy_reg};
      mrb_pkg::REG_RETRIES: rd_val = {16'h0000, retries_reg};
      mrb_pkg::REG_CPU_ID:  rd_val = {30'h0000_0000, cpu_id_reg};
      default: begin
        rd_hit = 1'b0;
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= mrb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? mrb_pkg::RESP_OKAY : mrb_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Conditional store with back-off and retry
  localparam logic [7:0] BACKOFF = 8'(mrb_pkg::BACKOFF_CYC);
  logic [7:0] backoff_reg;
  logic       mine;

  assign mine = post.post_ack && (post.post_ack_cpu == cpu_id_reg);
  assign post.post_addr = mrb_pkg::MBPTR_ADDR;
  assign post.post_cpu  = cpu_id_reg;
  assign post.post_data = {16'h0000, ptr_reg[47:6], 6'h00};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg        <= 1'b0;
      post.post_valid <= 1'b0;
      backoff_reg     <= '0;
      retries_reg     <= '0;
    end else begin
      if (go && !busy_reg) begin
        busy_reg        <= 1'b1;
        post.post_valid <= 1'b1;
      end else if (post.post_valid && mine) begin
        post.post_valid <= 1'b0;
        if (post.post_ok) begin
          busy_reg <= 1'b0;
        end else begin
          backoff_reg <= BACKOFF;
          retries_reg <= retries_reg + 16'd1;
        end
      end else if (busy_reg && !post.post_valid) begin
        if (backoff_reg == 8'd0) begin
          post.post_valid <= 1'b1;
        end else begin
          backoff_reg <= backoff_reg - 8'd1;
        end
      end
    end
  end
endmodule

// ---- mrb_monitor.sv ----
`timescale 1ns/100ps
module mrb_monitor (
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      rst_n,
  // Posting request
  input wire logic                      post_valid,
  input wire logic [47:0]               post_addr,
  input wire logic [mrb_pkg::CPU_W-1:0] post_cpu,
  input wire logic [63:0]               post_data,
  // Posting answer
  input wire logic                      post_ack,
  input wire logic                      post_ok,
  input wire logic [mrb_pkg::CPU_W-1:0] post_ack_cpu
);
  // ==========================================================
  // Posting port checks
  default clocking mon_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_post_answered: assert property (post_valid && !post_ack |=> post_ack)
    else $error("post not answered one cycle after it was taken");
  a_ack_one_pulse: assert property (post_ack |=> !post_ack)
    else $error("post answer lasted more than one cycle");
  a_ack_has_cause: assert property (post_ack |-> $past(post_valid) && !$past(post_ack))
    else $error("post answer without a pending store");
  a_ack_right_cpu: assert property (post_ack |-> post_ack_cpu == $past(post_cpu))
    else $error("post answer went to another processor");
  a_ptr_zero_bits: assert property (post_valid |-> post_data[5:0] == 6'h00 &&
                                    post_data[63:48] == 16'h0000)
    else $error("pointer value has bits outside 47 to 6");
  a_ptr_one_addr: assert property (post_valid |-> post_addr == mrb_pkg::MBPTR_ADDR)
    else $error("pointer register store at another address");
  a_req_held: assert property (post_valid && !post_ack |=> post_valid &&
                               $stable(post_data) && $stable(post_cpu))
    else $error("posting request changed before its answer");
  a_req_released: assert property (post_ack |=> !post_valid)
    else $error("posting request kept after its answer");

  c_post_accepted: cover property (post_ack && post_ok);
  c_post_refused: cover property (post_ack && !post_ok);
  c_second_cpu: cover property (post_ack && post_ok && post_ack_cpu == 2'h1);
endmodule

// ---- test_mailbox_remote_io_bridge.sv ----
`timescale 1ns/100ps
module test_mailbox_remote_io_bridge;
  // ==========================================================
  // Signals
  localparam logic [31:0] RD_WORD = 32'h5A5A_0F0F;
  localparam logic [61:0] STAT    = 62'h0ABC_DEF0_1234_5678;
  logic         ref_clk = 1'b0, rst_n = 1'b0;
  logic         awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic         awr, wr, bv, arr, rv, mem_req, mem_we, rb_req, rb_write, rb_special;
  logic [7:0]   awa = 8'h00, ara = 8'h00, rb_mask, rb_hose;
  logic [31:0]  wd = 32'h0000_0000, rdat, rb_rdata = 32'h0000_0000;
  logic [1:0]   bresp, rresp;
  logic         mem_ack = 1'b0, rb_ack = 1'b0, rb_err = 1'b0, err_sel = 1'b0, rb_stall = 1'b0;
  logic [47:0]  mem_addr;
  logic [63:0]  mem_wdata, rb_addr, rb_wdata, mem_rdata = 64'h0000_0000_0000_0000;
  logic [29:0]  rb_cmd;
  logic [61:0]  rb_status = 62'h0000_0000_0000_0000;
  logic [175:0] cap;
  logic [63:0]  mem [logic [47:0]];
  logic [47:0]  wlog [$];
  logic [7:0]   hlog [$];
  int           rd10, rd28, cyc, mismatches, tests_run;

  // ==========================================================
  // Design
  mrb_if mrb_if_i ();
  mrb_cpu mrb_cpu_i (.ref_clk(ref_clk), .rst_n(rst_n), .post(mrb_if_i.cpu),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp));
  mrb_bridge mrb_bridge_i (.ref_clk(ref_clk), .rst_n(rst_n), .post(mrb_if_i.bridge),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rb_req(rb_req), .rb_write(rb_write),
    .rb_special(rb_special), .rb_cmd(rb_cmd), .rb_mask(rb_mask), .rb_hose(rb_hose),
    .rb_addr(rb_addr), .rb_wdata(rb_wdata), .rb_ack(rb_ack), .rb_err(rb_err),
    .rb_status(rb_status), .rb_rdata(rb_rdata));
  mrb_monitor mrb_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .post_valid(mrb_if_i.post_valid), .post_addr(mrb_if_i.post_addr),
    .post_cpu(mrb_if_i.post_cpu), .post_data(mrb_if_i.post_data),
    .post_ack(mrb_if_i.post_ack), .post_ok(mrb_if_i.post_ok),
    .post_ack_cpu(mrb_if_i.post_ack_cpu));

  // ==========================================================
  // Memory and remote bus responders
  // Idle data lines are inverted every cycle so that a late sample never matches by luck.
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      mem_ack <= 1'b1;
      if (mem_we) begin
        mem[mem_addr] = mem_wdata;
        wlog.push_back(mem_addr);
      end else begin
        mem_rdata <= mem[mem_addr];
        rd10 += (mem_addr[5:0] == mrb_pkg::OFF_WDATA);
        rd28 += (mem_addr[5:0] == mrb_pkg::OFF_DONE);
      end
    end
  end
  always @(posedge ref_clk) begin
    rb_ack <= 1'b0;
    {rb_err, rb_status, rb_rdata} <= ~{rb_err, rb_status, rb_rdata};
    if (rb_req && !rb_ack && !rb_stall) begin
      rb_ack <= 1'b1;
      {rb_err, rb_status, rb_rdata} <= {err_sel, STAT, RD_WORD};
      cap <= {rb_write, rb_special, rb_cmd, rb_mask, rb_hose, rb_addr, rb_wdata};
      hlog.push_back(rb_hose);
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      test_done();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [175:0] exp, input logic [175:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    {awv, wv, br} <= 3'b111;
    awa <= a;
    wd <= d;
    do begin
      @(posedge ref_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!(bv && br));
    br <= 1'b0;
    chk("write response", er, bresp);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    {arv, rr} <= 2'b11;
    ara <= a;
    do begin
      @(posedge ref_clk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rv && rr));
    rr <= 1'b0;
    d = rdat;
    r = rresp;
  endtask

  // Stale completion bits are planted so that a bridge reading them would be caught.
  task automatic post(input logic [47:0] b, input logic [63:0] q0, output logic ok);
    logic [31:0] d;
    logic [1:0]  r;
    mem[b] = q0;
    mem[b + 8] = {q0[31:0], ~q0[31:0]};
    mem[b + 16] = {~q0[31:0], q0[31:0]};
    mem[b + 40] = 64'hFFFF_FFFF_FFFF_FFFE;
    axi_wr(mrb_pkg::REG_PTR_LO, b[31:0], mrb_pkg::RESP_OKAY);
    axi_wr(mrb_pkg::REG_PTR_HI, {16'h0000, b[47:32]}, mrb_pkg::RESP_OKAY);
    axi_wr(mrb_pkg::REG_CTRL, 32'h0000_0001, mrb_pkg::RESP_OKAY);
    ok = 1'b0;
    for (int i = 0; i < 6 && !ok; i++) begin
      axi_rd(mrb_pkg::REG_STATUS, d, r);
      ok = !d[0];
    end
  endtask

  task automatic run_mbx(input logic [47:0] b, input logic [63:0] q0, input logic e);
    logic ok;
    rd10 = 0;
    rd28 = 0;
    err_sel = e;
    wlog.delete();
    post(b, q0, ok);
    chk("accepted", 1'b1, ok);
    do @(posedge ref_clk); while (mem[b + 40][0] !== 1'b1);
    repeat (20) @(posedge ref_clk);
    chk("remote fields", {q0[31:0], q0[39:32], q0[55:48], mem[b + 8]}, cap[175:64]);
    chk("completion", {STAT, e, 1'b1}, mem[b + 40]);
    chk("completion fetched", 0, rd28);
    chk("last write", b + 40, wlog[$]);
    chk("write count", q0[31] ? 1 : 2, wlog.size());
    if (q0[31]) begin
      chk("remote write data", mem[b + 16], cap[63:0]);
    end else begin
      chk("read data", RD_WORD, mem[b + 32][31:0]);
      chk("data before done", b + 32, wlog[0]);
      chk("write data fetched", 0, rd10);
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(mrb_pkg::REG_RETRIES, d, r);
    chk("retries at reset", 32'h0000_0000, d);
    axi_wr(8'h20, 32'h0000_0001, mrb_pkg::RESP_SLVERR);
    axi_rd(8'h40, d, r);
    chk("unmapped read", mrb_pkg::RESP_SLVERR, r);
    axi_wr(mrb_pkg::REG_CPU_ID, 32'h0000_0002, mrb_pkg::RESP_OKAY);
    axi_rd(mrb_pkg::REG_CPU_ID, d, r);
    chk("cpu id", 32'h0000_0002, d);
    axi_rd(mrb_pkg::REG_CTRL, d, r);
    chk("control reads zero", 32'h0000_0000, d);
  endtask

  // Read, write, special read and special write, with hoses up to the last one.
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      run_mbx(48'hFEDC_BA98_7600 + 48'(i * 64), {8'h00, 8'(8'hFC + i), 8'h00,
        8'h3C ^ 8'(i), i[1], i[0], 30'h0123_4567}, i[0]);
    end
  endtask

  // With the remote bus stalled, processor 1 posts once, then processor 0 posts until its quota refuses it.
  task automatic t_order();
    logic        ok;
    logic [7:0]  exp [$];
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    hlog.delete();
    rb_stall = 1'b1;
    err_sel = 1'b0;
    ok = 1'b1;
    axi_wr(mrb_pkg::REG_CPU_ID, 32'h0000_0001, mrb_pkg::RESP_OKAY);
    for (int i = 0; i < 6 && ok; i++) begin
      post(48'h0000_0002_0000 + 48'(i * 64), {8'h00, 8'(8'h10 + i), 48'h0001}, ok);
      exp.push_back(8'(8'h10 + i));
      n = i;
      if (i == 0) axi_wr(mrb_pkg::REG_CPU_ID, 32'h0000_0000, mrb_pkg::RESP_OKAY);
    end
    chk("refused post index", 1 + mrb_pkg::QPER, n);
    axi_rd(mrb_pkg::REG_RETRIES, d, r);
    chk("retries counted", 1'b1, d != 32'h0000_0000);
    rb_stall = 1'b0;
    while (hlog.size() < exp.size()) @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
    for (int k = 0; k < exp.size(); k++) begin
      chk("remote order", exp[k], hlog[k]);
    end
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_modes();
    t_order();
    test_done();
  end
endmodule
